// *** include/timer_pwm_pkg.sv ***
// Purpose: Shared constants for the four-channel PWM timer.
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register.
// Notes: Field positions are bit indices inside each register word.
package timer_pwm_pkg;
  localparam int NUM_CH = 4;
  localparam int CH_IDX_W = 2;
  localparam int CNT_W_DEF = 16;
  localparam int BYTE_W = 8;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int WORD_LSB = 2;
  localparam int GRP_LSB = 4;
  // Register byte addresses
  localparam logic [ADDR_W-1:0] TSC_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] CNT_ADDR = 8'h04;
  localparam logic [ADDR_W-1:0] LIMIT_ADDR = 8'h08;
  localparam logic [ADDR_W-1:0] CSC_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] CMP_BASE = 8'h20;
  // timer_ctrl_status fields
  localparam int TSC_FLAG = 7;
  localparam int TSC_IE = 6;
  localparam int TSC_HALT = 5;
  localparam int TSC_CLR = 4;
  localparam int PS_LSB = 0;
  localparam int PS_W = 3;
  localparam logic [PS_W-1:0] PS_EXT = 3'h7;
  localparam int DIV_W_DEF = 6;
  // channel_ctrl_status fields
  localparam int CSC_FLAG = 7;
  localparam int CSC_IE = 6;
  localparam int CSC_MSB = 5;
  localparam int CSC_MSA = 4;
  localparam int CSC_ELSB = 3;
  localparam int CSC_ELSA = 2;
  localparam int CSC_TOV = 1;
  localparam int CSC_MAX = 0;
  // Edge/level select codes
  localparam logic [1:0] ELS_NONE = 2'h0;
  localparam logic [1:0] ELS_TOGGLE = 2'h1;
  localparam logic [1:0] ELS_CLEAR = 2'h2;
  localparam logic [1:0] ELS_SET = 2'h3;
  localparam logic [1:0] MODE_OFF = 2'h0;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** logic/pwm_channel_out.sv ***
// Purpose: Output level of one PWM channel from rollover and compare events.
// Assumes: Events are one-cycle strobes on the bus clock.
// Notes: Compare action is applied after the rollover toggle in the same cycle.
`timescale 1ns/100ps
module pwm_channel_out
  import timer_pwm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Events
  input wire logic roll,
  input wire logic match,
  // Configuration
  input wire logic tov,
  input wire logic [1:0] els,
  input wire logic full,
  // Pin level
  output logic out_r
);
  logic out_nxt;

  always_comb
  begin
    out_nxt = out_r;
    if (full && !tov)
      out_nxt = 1'b1;
    else
    begin
      if (roll && tov)
        out_nxt = ~out_r;
      if (match)
      begin
        case (els)
          ELS_TOGGLE: out_nxt = ~out_nxt;
          ELS_CLEAR: out_nxt = 1'b0;
          ELS_SET: out_nxt = 1'b1;
          default: out_nxt = out_nxt;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      out_r <= 1'b0;
    else
      out_r <= out_nxt;
  end

  property p_full;
    @(posedge clk) disable iff (!rst_n)
    full && !tov |=> out_r;
  endproperty
  a_full: assert property (p_full) else $error("full duty not high");

  property p_toggle;
    @(posedge clk) disable iff (!rst_n)
    roll && tov && !match && !full |=> out_r != $past(out_r);
  endproperty
  a_toggle: assert property (p_toggle) else $error("no toggle at rollover");

  property p_clear;
    @(posedge clk) disable iff (!rst_n)
    match && (els == ELS_CLEAR) && !(full && !tov) |=> !out_r;
  endproperty
  a_clear: assert property (p_clear) else $error("compare did not clear");
endmodule

// *** logic/pwm_prescaler.sv ***
// Purpose: Counter clock selection: bus clock divided, or external pin edges.
// Assumes: External clock pin is asynchronous and slower than half the bus clock.
// Notes: tick is a one-cycle advance strobe for the shared counter.
`timescale 1ns/100ps
module pwm_prescaler
  import timer_pwm_pkg::*;
#(
  parameter int DIV_W = DIV_W_DEF
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic [PS_W-1:0] sel,
  input wire logic clear,
  input wire logic ext_clk_pin,
  // Counter advance
  output logic tick
);
  if (DIV_W < DIV_W_DEF)
  begin : g_chk
    $error("DIV_W too small for divide by 64");
  end

  logic [DIV_W-1:0] div_r, div_nxt, mask;
  // Two sync flops, then edge history
  logic [2:0] ext_r, ext_nxt;

  always_comb
  begin
    ext_nxt = {ext_r[1:0], ext_clk_pin};
    div_nxt = clear ? '0 : div_r + 1'b1;
    mask = ~({DIV_W{1'b1}} << sel);
    if (sel == PS_EXT)
      tick = ~clear & ext_r[1] & ~ext_r[2];
    else
      tick = ~clear & ((div_r & mask) == mask);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_r <= '0;
      ext_r <= '0;
    end
    else
    begin
      div_r <= div_nxt;
      ext_r <= ext_nxt;
    end
  end

  property p_div2;
    @(posedge clk) disable iff (!rst_n)
    (sel == 3'h1) && !clear && tick |=> !tick;
  endproperty
  a_div2: assert property (p_div2) else $error("divide by two ticked twice");
endmodule

// *** logic/timer_pwm_channels.sv ***
// Purpose: Four-channel 16-bit PWM timer with AXI4-Lite registers.
// Assumes: One bus clock; external counter clock pin is asynchronous.
// Notes: Pairs 0/1 and 2/3 may link for buffered width updates.
`timescale 1ns/100ps
module timer_pwm_channels
  import timer_pwm_pkg::*;
#(
  parameter int CNT_W = CNT_W_DEF
)
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [DATA_W-1:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [DATA_W-1:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Timer pins
  input wire logic EXT_CLK_PIN,
  output logic [NUM_CH-1:0] CH_PIN_OUT,
  output logic [NUM_CH-1:0] CH_PIN_OE_N,
  // Interrupt requests
  output logic ROLLOVER_IRQ,
  output logic [NUM_CH-1:0] CHANNEL_IRQ
);
  if (CNT_W < BYTE_W + 1 || CNT_W > 2 * BYTE_W)
  begin : g_chk
    $error("CNT_W must fit two byte lanes");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State
  logic awready_r, awready_nxt, wready_r, wready_nxt, bvalid_r, bvalid_nxt;
  logic arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt, rd_word;
  logic [CNT_W-1:0] cnt_r, cnt_nxt, limit_r, limit_nxt, cnt_step;
  logic [CNT_W-1:0] cmp_r [NUM_CH];
  logic [CNT_W-1:0] cmp_nxt [NUM_CH];
  logic [NUM_CH-1:0][CSC_IE:0] csc_r, csc_nxt;
  logic [NUM_CH-1:0] cflag_r, cflag_nxt, carm_r, carm_nxt;
  logic [NUM_CH-1:0] oe_n_r, oe_n_nxt, chirq_r, chirq_nxt, match, active;
  logic [NUM_CH/2-1:0] sel_r, sel_nxt, pend_r, pend_nxt;
  logic [PS_W-1:0] ps_r, ps_nxt;
  logic halt_r, halt_nxt, clr_r, clr_nxt, tflag_r, tflag_nxt, tie_r, tie_nxt;
  logic tarm_r, tarm_nxt, inh_r, inh_nxt, rirq_r, rirq_nxt;
  logic tick, step, roll, wr_hs, rd_hs, wr_map, rd_map;
  logic [DATA_W-1:0] wd;
  logic [CH_IDX_W-1:0] wa_ch, ra_ch;
  logic wa_tsc, wa_lim, wa_csc, wa_cmp, ra_tsc, ra_csc;

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode
  assign wd = S_AXI_WDATA;
  assign wa_ch = S_AXI_AWADDR[GRP_LSB-1:WORD_LSB];
  assign ra_ch = S_AXI_ARADDR[GRP_LSB-1:WORD_LSB];
  assign wa_tsc = S_AXI_AWADDR[ADDR_W-1:WORD_LSB] == TSC_ADDR[ADDR_W-1:WORD_LSB];
  assign wa_lim = S_AXI_AWADDR[ADDR_W-1:WORD_LSB] == LIMIT_ADDR[ADDR_W-1:WORD_LSB];
  assign wa_csc = S_AXI_AWADDR[ADDR_W-1:GRP_LSB] == CSC_BASE[ADDR_W-1:GRP_LSB];
  assign wa_cmp = S_AXI_AWADDR[ADDR_W-1:GRP_LSB] == CMP_BASE[ADDR_W-1:GRP_LSB];
  assign ra_tsc = S_AXI_ARADDR[ADDR_W-1:WORD_LSB] == TSC_ADDR[ADDR_W-1:WORD_LSB];
  assign ra_csc = S_AXI_ARADDR[ADDR_W-1:GRP_LSB] == CSC_BASE[ADDR_W-1:GRP_LSB];
  assign wr_map = wa_tsc | wa_lim | wa_csc | wa_cmp
    | (S_AXI_AWADDR[ADDR_W-1:WORD_LSB] == CNT_ADDR[ADDR_W-1:WORD_LSB]);
  assign wr_hs = awready_r & S_AXI_AWVALID & S_AXI_WVALID;
  assign rd_hs = arready_r & S_AXI_ARVALID;

  always_comb
  begin
    rd_word = '0;
    rd_map = 1'b1;
    if (ra_tsc)
    begin
      rd_word[TSC_FLAG] = tflag_r;
      rd_word[TSC_IE] = tie_r;
      rd_word[TSC_HALT] = halt_r;
      rd_word[PS_LSB +: PS_W] = ps_r;
    end
    else if (S_AXI_ARADDR[ADDR_W-1:WORD_LSB] == CNT_ADDR[ADDR_W-1:WORD_LSB])
      rd_word[CNT_W-1:0] = cnt_r;
    else if (S_AXI_ARADDR[ADDR_W-1:WORD_LSB] == LIMIT_ADDR[ADDR_W-1:WORD_LSB])
      rd_word[CNT_W-1:0] = limit_r;
    else if (ra_csc)
      rd_word[CSC_FLAG:0] = {cflag_r[ra_ch], csc_r[ra_ch]};
    else if (S_AXI_ARADDR[ADDR_W-1:GRP_LSB] == CMP_BASE[ADDR_W-1:GRP_LSB])
      rd_word[CNT_W-1:0] = cmp_r[ra_ch];
    else
      rd_map = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: one write and one read in flight at most
  always_comb
  begin
    awready_nxt = S_AXI_AWVALID & S_AXI_WVALID & ~awready_r & ~bvalid_r;
    wready_nxt = awready_nxt;
    bvalid_nxt = wr_hs | (bvalid_r & ~S_AXI_BREADY);
    bresp_nxt = wr_hs ? (wr_map ? RESP_OKAY : RESP_SLVERR) : bresp_r;
    arready_nxt = S_AXI_ARVALID & ~arready_r & ~rvalid_r;
    rvalid_nxt = rd_hs | (rvalid_r & ~S_AXI_RREADY);
    rdata_nxt = rd_hs ? rd_word : rdata_r;
    rresp_nxt = rd_hs ? (rd_map ? RESP_OKAY : RESP_SLVERR) : rresp_r;
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end
    else
    begin
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  assign S_AXI_AWREADY = awready_r;
  assign S_AXI_WREADY = wready_r;
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;
  assign S_AXI_ARREADY = arready_r;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA = rdata_r;
  assign S_AXI_RRESP = rresp_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Counter and channels
  pwm_prescaler i_pwm_prescaler (
    .clk(CLK),
    .rst_n(RST_N),
    .sel(ps_r),
    .clear(clr_r),
    .ext_clk_pin(EXT_CLK_PIN),
    .tick(tick)
  );

  assign step = tick & ~halt_r & ~clr_r;
  assign roll = step & (cnt_r == limit_r);
  assign cnt_step = (cnt_r == limit_r) ? '0 : cnt_r + 1'b1;

  for (genvar g = 0; g < NUM_CH; g++)
  begin : g_ch
    localparam int E = g - (g % 2);
    logic linked;
    logic [CNT_W-1:0] eff;
    // Link bit alone decides buffering, low mode bit ignored
    assign linked = csc_r[E][CSC_MSB];
    assign eff = ((g % 2 == 0) && linked && sel_r[g / 2]) ? cmp_r[E + 1] : cmp_r[g];
    assign active[g] = (csc_r[g][CSC_MSB -: 2] != MODE_OFF) && !((g % 2 == 1) && linked);
    assign match[g] = step & active[g] & (cnt_step == eff);
    pwm_channel_out i_pwm_channel_out (
      .clk(CLK),
      .rst_n(RST_N),
      .roll(roll & active[g]),
      .match(match[g]),
      .tov(csc_r[g][CSC_TOV]),
      .els(csc_r[g][CSC_ELSB -: 2]),
      .full(csc_r[g][CSC_MAX]),
      .out_r(CH_PIN_OUT[g])
    );
  end

  always_comb
  begin
    cnt_nxt = cnt_r;
    limit_nxt = limit_r;
    halt_nxt = halt_r;
    clr_nxt = 1'b0;
    ps_nxt = ps_r;
    tflag_nxt = tflag_r;
    tie_nxt = tie_r;
    tarm_nxt = tarm_r;
    inh_nxt = inh_r;
    csc_nxt = csc_r;
    cflag_nxt = cflag_r;
    carm_nxt = carm_r;
    cmp_nxt = cmp_r;
    sel_nxt = sel_r;
    pend_nxt = pend_r;
    if (clr_r)
      cnt_nxt = '0;
    else if (step)
      cnt_nxt = cnt_step;
    if (rd_hs && ra_tsc && tflag_r)
      tarm_nxt = 1'b1;
    if (wr_hs && wa_tsc && S_AXI_WSTRB[0])
    begin
      tie_nxt = wd[TSC_IE];
      halt_nxt = wd[TSC_HALT];
      clr_nxt = wd[TSC_CLR];
      ps_nxt = wd[PS_LSB +: PS_W];
      if (!wd[TSC_FLAG] && tarm_r)
        tflag_nxt = 1'b0;
      tarm_nxt = 1'b0;
    end
    if (wr_hs && wa_lim)
    begin
      if (S_AXI_WSTRB[1])
      begin
        limit_nxt[CNT_W-1:BYTE_W] = wd[CNT_W-1:BYTE_W];
        inh_nxt = 1'b1;
      end
      if (S_AXI_WSTRB[0])
      begin
        limit_nxt[BYTE_W-1:0] = wd[BYTE_W-1:0];
        inh_nxt = 1'b0;
      end
    end
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (rd_hs && ra_csc && ra_ch == CH_IDX_W'(i) && cflag_r[i])
        carm_nxt[i] = 1'b1;
      if (wr_hs && wa_csc && wa_ch == CH_IDX_W'(i) && S_AXI_WSTRB[0])
      begin
        csc_nxt[i] = wd[CSC_IE:0];
        if (!wd[CSC_FLAG] && carm_r[i])
          cflag_nxt[i] = 1'b0;
        carm_nxt[i] = 1'b0;
      end
      if (wr_hs && wa_cmp && wa_ch == CH_IDX_W'(i))
      begin
        if (S_AXI_WSTRB[0])
          cmp_nxt[i][BYTE_W-1:0] = wd[BYTE_W-1:0];
        if (S_AXI_WSTRB[1])
          cmp_nxt[i][CNT_W-1:BYTE_W] = wd[CNT_W-1:BYTE_W];
        pend_nxt[i / 2] = (i % 2 == 1);
      end
      // Set wins over a clear landing in the same cycle
      if (match[i])
      begin
        cflag_nxt[i] = 1'b1;
        carm_nxt[i] = 1'b0;
      end
    end
    if (roll)
    begin
      sel_nxt = pend_r;
      tarm_nxt = 1'b0;
      if (!inh_r)
        tflag_nxt = 1'b1;
    end
    for (int p = 0; p < NUM_CH / 2; p++)
    begin
      if (!csc_r[2 * p][CSC_MSB])
      begin
        sel_nxt[p] = 1'b0;
        pend_nxt[p] = 1'b0;
      end
    end
    for (int i = 0; i < NUM_CH; i++)
    begin
      oe_n_nxt[i] = !(active[i] && csc_r[i][CSC_ELSB -: 2] != ELS_NONE);
      chirq_nxt[i] = cflag_r[i] & csc_r[i][CSC_IE];
    end
    rirq_nxt = tflag_r & tie_r;
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      cnt_r <= '0;
      limit_r <= '1;
      halt_r <= 1'b1;
      clr_r <= 1'b0;
      ps_r <= '0;
      tflag_r <= 1'b0;
      tie_r <= 1'b0;
      tarm_r <= 1'b0;
      inh_r <= 1'b0;
      csc_r <= '0;
      cflag_r <= '0;
      carm_r <= '0;
      cmp_r <= '{default: '0};
      sel_r <= '0;
      pend_r <= '0;
      oe_n_r <= '1;
      chirq_r <= '0;
      rirq_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      limit_r <= limit_nxt;
      halt_r <= halt_nxt;
      clr_r <= clr_nxt;
      ps_r <= ps_nxt;
      tflag_r <= tflag_nxt;
      tie_r <= tie_nxt;
      tarm_r <= tarm_nxt;
      inh_r <= inh_nxt;
      csc_r <= csc_nxt;
      cflag_r <= cflag_nxt;
      carm_r <= carm_nxt;
      cmp_r <= cmp_nxt;
      sel_r <= sel_nxt;
      pend_r <= pend_nxt;
      oe_n_r <= oe_n_nxt;
      chirq_r <= chirq_nxt;
      rirq_r <= rirq_nxt;
    end
  end

  assign CH_PIN_OE_N = oe_n_r;
  assign CHANNEL_IRQ = chirq_r;
  assign ROLLOVER_IRQ = rirq_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_count;
    @(posedge CLK) disable iff (!RST_N)
    step && !roll |=> cnt_r == $past(cnt_r) + 1'b1;
  endproperty
  a_count: assert property (p_count) else $error("counter did not advance");

  property p_wrap;
    @(posedge CLK) disable iff (!RST_N)
    roll |=> cnt_r == '0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap");

  property p_roll_flag;
    @(posedge CLK) disable iff (!RST_N)
    roll && !inh_r |=> tflag_r;
  endproperty
  a_roll_flag: assert property (p_roll_flag) else $error("rollover flag missing");

  property p_flag_hold;
    @(posedge CLK) disable iff (!RST_N)
    tflag_r && !tarm_r |=> tflag_r;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag cleared unarmed");

  property p_inhibit;
    @(posedge CLK) disable iff (!RST_N)
    inh_r && !tflag_r |=> !tflag_r;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("flag set while inhibited");

  property p_swap;
    @(posedge CLK) disable iff (!RST_N)
    roll && csc_r[0][CSC_MSB] |=> sel_r[0] == $past(pend_r[0]);
  endproperty
  a_swap: assert property (p_swap) else $error("buffer swap wrong");

  property p_release;
    @(posedge CLK) disable iff (!RST_N)
    csc_r[0][CSC_MSB] |=> CH_PIN_OE_N[1];
  endproperty
  a_release: assert property (p_release) else $error("odd pin still driven");

  property p_clear;
    @(posedge CLK) disable iff (!RST_N)
    clr_r |=> cnt_r == '0 ##1 !clr_r;
  endproperty
  a_clear: assert property (p_clear) else $error("counter clear failed");

  property p_chirq;
    @(posedge CLK) disable iff (!RST_N)
    cflag_r[0] && csc_r[0][CSC_IE] |=> CHANNEL_IRQ[0];
  endproperty
  a_chirq: assert property (p_chirq) else $error("channel irq missing");
endmodule

// *** testbench/timer_pwm_channels_tb.sv ***
// Purpose: Self-checking bench for the four-channel PWM timer.
// Assumes: Registers reached over AXI4-Lite as the package maps them.
// Notes: Duty and period are measured on pin 0 by counting clock cycles.
`timescale 1ns/100ps
module timer_pwm_channels_tb
  import timer_pwm_pkg::*;
;
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end

logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, ext_clk;
logic [ADDR_W-1:0] awaddr, araddr;
logic [DATA_W-1:0] wdata, rdata, rd;
logic [3:0] wstrb;
logic awready, wready, bvalid, arready, rvalid, roll_irq;
logic [1:0] bresp, rresp;
logic [NUM_CH-1:0] pin_out, pin_oe_n, ch_irq;
int n_errors, tests_run;

timer_pwm_channels i_timer_pwm_channels (
  .CLK(clk), .RST_N(rst_n),
  .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
  .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
  .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
  .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
  .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
  .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .EXT_CLK_PIN(ext_clk),
  .CH_PIN_OUT(pin_out), .CH_PIN_OE_N(pin_oe_n),
  .ROLLOVER_IRQ(roll_irq), .CHANNEL_IRQ(ch_irq)
);

always #5 clk = ~clk;

// External counter clock: rising edge every 8 bus clocks
logic [2:0] ext_div = 3'h0;
always @(posedge clk) ext_div <= ext_div + 3'h1;
assign ext_clk = ext_div[2];

////////////////////////////////////////////////////////////////////////
task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
  input logic [3:0] s = 4'h3, input logic [1:0] er = RESP_OKAY);
  logic aw_ok, w_ok;
  aw_ok = 1'b0;
  w_ok = 1'b0;
  awaddr <= a;
  wdata <= d;
  wstrb <= s;
  awvalid <= 1'b1;
  wvalid <= 1'b1;
  bready <= 1'b1;
  while (!(aw_ok && w_ok))
  begin
    @(posedge clk);
    if (awready === 1'b1) awvalid <= 1'b0;
    if (wready === 1'b1) wvalid <= 1'b0;
    aw_ok = aw_ok | (awready === 1'b1);
    w_ok = w_ok | (wready === 1'b1);
  end
  do @(posedge clk); while (bvalid !== 1'b1);
  bready <= 1'b0;
  `CHK(bresp, er)
endtask

task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [1:0] er = RESP_OKAY);
  araddr <= a;
  arvalid <= 1'b1;
  rready <= 1'b1;
  do @(posedge clk); while (arready !== 1'b1);
  arvalid <= 1'b0;
  while (rvalid !== 1'b1) @(posedge clk);
  rd = rdata;
  rready <= 1'b0;
  `CHK(rresp, er)
endtask

// Settle one long period first, then count high cycles and rising edges
task automatic duty(input int exp_hi, input int exp_rs);
  int hi, rs;
  logic last;
  hi = 0;
  rs = 0;
  repeat (300) @(posedge clk);
  last = pin_out[0];
  repeat (512)
  begin
    @(posedge clk);
    hi += int'(pin_out[0] === 1'b1);
    rs += int'(pin_out[0] === 1'b1 && last === 1'b0);
    last = pin_out[0];
  end
  `CHK(hi, exp_hi)
  `CHK(rs, exp_rs)
endtask

task automatic print_verdict();
  $display("Checks %0d mismatches %0d", tests_run, n_errors);
  if (n_errors == 0 && tests_run > 0)
    $display("Simulation passed");
  else
    $display("Simulation failed");
  $finish;
endtask

////////////////////////////////////////////////////////////////////////
initial
begin
  clk = 0;
  rst_n = 0;
  awvalid = 0;
  wvalid = 0;
  bready = 0;
  arvalid = 0;
  rready = 0;
  awaddr = '0;
  araddr = '0;
  wdata = '0;
  wstrb = '0;
  n_errors = 0;
  tests_run = 0;
  repeat (6) @(posedge clk);
  rst_n <= 1'b1;
  @(posedge clk);
  `CHK(pin_oe_n, 4'hf)
  rd_reg(TSC_ADDR);
  `CHK(rd, 32'h20)
  rd_reg(LIMIT_ADDR);
  `CHK(rd, 32'hffff)
  // Documented start-up order, 8-bit period, half duty
  wr(TSC_ADDR, 32'h30);
  wr(LIMIT_ADDR, 32'hff);
  wr(CMP_BASE, 32'h80);
  wr(CSC_BASE, 32'h1a);
  wr(TSC_ADDR, 32'h00);
  duty(256, 2);
  // Writing 1 to the flag keeps it; read then write 0 clears it
  // Halted, so no rollover slips in between the read and the clear
  wr(TSC_ADDR, 32'he0);
  repeat (3) @(posedge clk);
  `CHK(roll_irq, 1'b1)
  rd_reg(TSC_ADDR);
  `CHK(rd, 32'he0)
  wr(TSC_ADDR, 32'h60);
  rd_reg(TSC_ADDR);
  `CHK(rd, 32'h60)
  `CHK(roll_irq, 1'b0)
  wr(TSC_ADDR, 32'h40);
  rd_reg(CSC_BASE);
  `CHK(rd, 32'h9a)
  `CHK(ch_irq, 4'h0)
  wr(CSC_BASE, 32'hda);
  repeat (2) @(posedge clk);
  `CHK(ch_irq, 4'h1)
  wr(CSC_BASE, 32'h18);
  duty(0, 0);
  wr(CSC_BASE, 32'h19);
  duty(512, 0);
  // Linked pair: odd pin released, odd compare takes over at rollover
  wr(CSC_BASE + 8'h04, 32'h1a);
  repeat (3) @(posedge clk);
  `CHK(pin_oe_n[1], 1'b0)
  wr(CMP_BASE, 32'h40);
  wr(CSC_BASE, 32'h2a);
  duty(128, 2);
  `CHK(pin_oe_n[1], 1'b1)
  wr(CMP_BASE + 8'h04, 32'hc0);
  duty(384, 2);
  wr(CSC_BASE, 32'h3a);
  duty(384, 2);
  `CHK(pin_oe_n[1], 1'b1)
  wr(CMP_BASE, 32'h40);
  duty(128, 2);
  // Every internal divide: limit 3, compare 2
  // Halt and clear first: a counter above the new limit would run to ffff
  wr(TSC_ADDR, 32'h30);
  wr(LIMIT_ADDR, 32'h3);
  wr(CMP_BASE, 32'h2);
  wr(CSC_BASE, 32'h1a);
  for (int k = 0; k < 7; k++)
  begin
    wr(TSC_ADDR, k);
    duty(256, 128 >> k);
  end
  wr(TSC_ADDR, 32'h7);
  duty(256, 16);
  // High limit byte alone holds the flag off until the low byte lands
  wr(TSC_ADDR, 32'h20);
  rd_reg(TSC_ADDR);
  wr(LIMIT_ADDR, 32'h0, 4'h2);
  wr(TSC_ADDR, 32'h00);
  repeat (20) @(posedge clk);
  rd_reg(TSC_ADDR);
  `CHK(rd[TSC_FLAG], 1'b0)
  wr(LIMIT_ADDR, 32'h3, 4'h1);
  repeat (10) @(posedge clk);
  rd_reg(TSC_ADDR);
  `CHK(rd[TSC_FLAG], 1'b1)
  rd_reg(8'h0c, RESP_SLVERR);
  `CHK(rd, 32'h0)
  wr(8'h0c, 32'h1, 4'h3, RESP_SLVERR);
  wr(TSC_ADDR, 32'h30);
  rd_reg(CNT_ADDR);
  `CHK(rd, 32'h0)
  rd_reg(TSC_ADDR);
  `CHK(rd[TSC_CLR], 1'b0)
  print_verdict();
end

initial
begin
  repeat (60000) @(posedge clk);
  n_errors++;
  $display("[ERR] %0t watchdog expired", $time);
  print_verdict();
end

endmodule
